// file: logic/qddr_pkg.sv
// Constants shared by the quad DDR read block
package qddr_pkg;
  localparam logic [7:0] OP_QDDR_READ = 8'hED;
  localparam logic [7:0] OP_QDDR_READ_4B = 8'hEE;
  localparam logic [7:0] REG_CFG_OFF = 8'h00;
  localparam logic [7:0] REG_PATTERN_OFF = 8'h04;
  localparam logic [7:0] REG_STATUS_OFF = 8'h08;
  localparam logic [7:0] REG_MEM_PTR_OFF = 8'h0C;
  localparam logic [7:0] REG_MEM_DATA_OFF = 8'h10;
  localparam int CFG_EXT_ADDR_BIT = 0;
  localparam int CFG_QUAD_BIT = 1;
  localparam int CFG_LEARN_BIT = 2;
  localparam int CFG_LC_LSB = 4;
  localparam int CFG_LC_W = 4;
  localparam logic [7:0] CFG_RESET = 8'h80;
  localparam logic [7:0] PATTERN_RESET = 8'h34;
  localparam logic [4:0] CMD_BITS = 5'h08;
  localparam logic [4:0] ADDR_NIB_3B = 5'h06;
  localparam logic [4:0] ADDR_NIB_4B = 5'h08;
  localparam logic [4:0] PREAMBLE_TOP = 5'h09;
  localparam logic [4:0] PREAMBLE_BOT = 5'h02;
  localparam logic [3:0] CONT_EXIT_MAX = 4'h8;
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_CMD = 7'h02,
    ST_ADDR = 7'h04,
    ST_MODE = 7'h08,
    ST_DUMMY = 7'h10,
    ST_DATA = 7'h20,
    ST_SKIP = 7'h40
  } link_state_e;
endpackage : qddr_pkg

// file: logic/link_sync.sv
// Two-flop synchroniser with edge detection for link pins
`timescale 1ns/1ns
`default_nettype none
module link_sync #(
  parameter int W = 6
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] level_out,
  output logic [W-1:0] rise_out,
  output logic [W-1:0] fall_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] prev_q;

  // Pins idle high so no false edge appears right after reset
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      meta_q <= {W{1'b1}};
      sync_q <= {W{1'b1}};
      prev_q <= {W{1'b1}};
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level_out = sync_q;
  assign rise_out = sync_q & ~prev_q;
  assign fall_out = ~sync_q & prev_q;
endmodule : link_sync
`default_nettype wire

// file: logic/qddr_read_top.sv
// Quad DDR flash read engine with APB configuration and array loading
//
// The implementer's own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - Read opcode accepted only while the quad enable bit is one.
// - EDh takes 3 or 4 address bytes by extended mode; EEh always 4.
// - Address arrives as nibbles on IO0..IO3 on both clock edges.
// - Mode byte follows address, then array data four bits per edge.
// - Dummy cycles follow the mode byte; IO inputs are ignored there.
// - Dummy cycle count comes from the latency code field.
// - Complementary mode nibbles enter continuous mode; next frame starts with address.
// - Non-complementary mode bits drop continuous mode at next select cycle.
// - Select low for eight clocks or fewer without address drops continuous mode.
// - Any start byte allowed; read address steps by one per byte.
// - Address wraps to zero past the top; streaming continues.
// - No pause function during this read.
// - Preamble drives IO during the four cycles before first data.
// - Learning pattern driven identically on all four lines.
module qddr_read_top #(
  parameter int MEM_AW = 8
) (
  input wire logic REF_CLK_IN,
  input wire logic RSTN_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  input wire logic SCK_IN,
  input wire logic CS_N_IN,
  input wire logic [3:0] SIO_IN,
  output logic [3:0] SIO_OUT,
  output logic [3:0] SIO_OE_OUT
);
  logic [5:0] lvl;
  logic [5:0] rise;
  logic [5:0] fall;
  logic sck_rise;
  logic sck_fall;
  logic sck_edge;
  logic cs_fall;
  logic cs_high;
  logic [3:0] io;
  logic [7:0] cfg_q;
  logic [7:0] pattern_q;
  logic [MEM_AW-1:0] mem_ptr_q;
  logic [7:0] mem [0:(1<<MEM_AW)-1];
  qddr_pkg::link_state_e state_q;
  logic [4:0] cnt_q;
  logic [6:0] sh_q;
  logic [31:0] addr_q;
  logic [3:0] mode_hi_q;
  logic wide_q;
  logic cont_q;
  logic cont_frame_q;
  logic [3:0] rises_q;
  logic [7:0] mem_rd;
  logic [7:0] op;
  logic [3:0] lc;
  logic nib_take;
  logic pready_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic [3:0] out_q;
  logic [3:0] oe_q;
  logic [31:0] rd_val;
  logic rd_hit;

  function automatic logic is_read(input logic [7:0] code);
    is_read = (code == qddr_pkg::OP_QDDR_READ) || (code == qddr_pkg::OP_QDDR_READ_4B);
  endfunction : is_read

  link_sync #(.W(6)) u_sync (
    .clk_in(REF_CLK_IN),
    .rstn_in(RSTN_IN),
    .async_in({SIO_IN, CS_N_IN, SCK_IN}),
    .level_out(lvl),
    .rise_out(rise),
    .fall_out(fall)
  );

  assign cs_high = lvl[1];
  assign cs_fall = fall[1];
  assign sck_rise = rise[0] & ~cs_high;
  assign sck_fall = fall[0] & ~cs_high;
  assign sck_edge = sck_rise | sck_fall;
  // IO3 is plain data here; there is no pause input to honour
  assign io = lvl[5:2];
  assign op = {sh_q, io[0]};
  assign lc = cfg_q[qddr_pkg::CFG_LC_LSB +: qddr_pkg::CFG_LC_W];
  // Only the low address bits index the array, so the count wraps at its top
  assign mem_rd = mem[addr_q[MEM_AW-1:0]];
  // Even remaining count takes a rising-edge nibble, odd a falling one
  assign nib_take = (sck_rise & ~cnt_q[0]) | (sck_fall & cnt_q[0]);

  // Link sequencer
  always_ff @(posedge REF_CLK_IN) begin
    if (!RSTN_IN) begin
      state_q <= qddr_pkg::ST_IDLE;
      cnt_q <= 5'h00;
      sh_q <= 7'h00;
      addr_q <= 32'h0000_0000;
      mode_hi_q <= 4'h0;
      wide_q <= 1'b0;
    end else if (cs_high) begin
      // Select high mid-mode simply aborts; mode state is left as it was
      state_q <= qddr_pkg::ST_IDLE;
    end else if (cs_fall) begin
      if (cont_q) begin
        state_q <= qddr_pkg::ST_ADDR;
        cnt_q <= wide_q ? qddr_pkg::ADDR_NIB_4B : qddr_pkg::ADDR_NIB_3B;
      end else begin
        state_q <= qddr_pkg::ST_CMD;
        cnt_q <= qddr_pkg::CMD_BITS;
      end
      addr_q <= 32'h0000_0000;
    end else if (sck_edge) begin
      case (state_q)
        qddr_pkg::ST_CMD: begin
          if (sck_rise) begin
            sh_q <= op[6:0];
            cnt_q <= cnt_q - 5'h01;
            if (cnt_q == 5'h01) begin
              if (cfg_q[qddr_pkg::CFG_QUAD_BIT] && is_read(op)) begin
                state_q <= qddr_pkg::ST_ADDR;
                wide_q <= (op == qddr_pkg::OP_QDDR_READ_4B) ||
                  cfg_q[qddr_pkg::CFG_EXT_ADDR_BIT];
                cnt_q <= ((op == qddr_pkg::OP_QDDR_READ_4B) ||
                  cfg_q[qddr_pkg::CFG_EXT_ADDR_BIT]) ?
                  qddr_pkg::ADDR_NIB_4B : qddr_pkg::ADDR_NIB_3B;
              end else begin
                state_q <= qddr_pkg::ST_SKIP;
              end
            end
          end
        end
        qddr_pkg::ST_ADDR: begin
          if (nib_take) begin
            addr_q <= {addr_q[27:0], io};
            cnt_q <= cnt_q - 5'h01;
            if (cnt_q == 5'h01) begin
              state_q <= qddr_pkg::ST_MODE;
            end
          end
        end
        qddr_pkg::ST_MODE: begin
          if (sck_rise) begin
            mode_hi_q <= io;
          end else begin
            state_q <= qddr_pkg::ST_DUMMY;
            cnt_q <= {lc, 1'b1};
          end
        end
        qddr_pkg::ST_DUMMY: begin
          // IO inputs are not looked at while counting the latency
          cnt_q <= cnt_q - 5'h01;
          if (cnt_q == 5'h01) begin
            state_q <= qddr_pkg::ST_DATA;
          end
        end
        qddr_pkg::ST_DATA: begin
          if (sck_fall) begin
            addr_q <= addr_q + 32'h0000_0001;
          end
        end
        default: begin
          state_q <= state_q;
        end
      endcase
    end
  end

  // Continuous read mode flag
  always_ff @(posedge REF_CLK_IN) begin
    if (!RSTN_IN) begin
      cont_q <= 1'b0;
      cont_frame_q <= 1'b0;
      rises_q <= 4'h0;
    end else begin
      if (cs_fall) begin
        cont_frame_q <= cont_q;
        rises_q <= 4'h0;
      end else if (sck_rise && rises_q != (qddr_pkg::CONT_EXIT_MAX + 4'h1)) begin
        rises_q <= rises_q + 4'h1;
      end
      if (state_q == qddr_pkg::ST_MODE && sck_fall) begin
        cont_q <= (io == ~mode_hi_q);
      end else if (rise[1] && cont_frame_q && rises_q <= qddr_pkg::CONT_EXIT_MAX &&
          state_q == qddr_pkg::ST_ADDR) begin
        cont_q <= 1'b0;
      end
    end
  end

  // Pin drivers; the host is expected to be off the bus before these turn on
  always_ff @(posedge REF_CLK_IN) begin
    if (!RSTN_IN) begin
      out_q <= 4'h0;
      oe_q <= 4'h0;
    end else if (cs_high) begin
      oe_q <= 4'h0;
    end else if (sck_edge) begin
      if (state_q == qddr_pkg::ST_DUMMY && cnt_q == 5'h01) begin
        out_q <= mem_rd[7:4];
        oe_q <= 4'hF;
      end else if (state_q == qddr_pkg::ST_DUMMY && cfg_q[qddr_pkg::CFG_LEARN_BIT] &&
          cnt_q >= qddr_pkg::PREAMBLE_BOT && cnt_q <= qddr_pkg::PREAMBLE_TOP) begin
        out_q <= {4{pattern_q[3'(cnt_q - qddr_pkg::PREAMBLE_BOT)]}};
        oe_q <= 4'hF;
      end else if (state_q == qddr_pkg::ST_DATA) begin
        out_q <= sck_rise ? mem_rd[7:4] : mem_rd[3:0];
        oe_q <= 4'hF;
      end else begin
        oe_q <= 4'h0;
      end
    end
  end

  always_comb begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    if (PADDR_IN == qddr_pkg::REG_CFG_OFF) begin
      rd_val = {24'h00_0000, cfg_q};
    end else if (PADDR_IN == qddr_pkg::REG_PATTERN_OFF) begin
      rd_val = {24'h00_0000, pattern_q};
    end else if (PADDR_IN == qddr_pkg::REG_STATUS_OFF) begin
      rd_val = {24'h00_0000, cont_q, state_q};
    end else if (PADDR_IN == qddr_pkg::REG_MEM_PTR_OFF) begin
      rd_val = 32'(mem_ptr_q);
    end else if (PADDR_IN == qddr_pkg::REG_MEM_DATA_OFF) begin
      rd_val = {24'h00_0000, mem[mem_ptr_q]};
    end else begin
      rd_hit = 1'b0;
    end
  end

  // APB slave: answer is ready in the first access cycle
  always_ff @(posedge REF_CLK_IN) begin
    if (!RSTN_IN) begin
      pready_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
      cfg_q <= qddr_pkg::CFG_RESET;
      pattern_q <= qddr_pkg::PATTERN_RESET;
      mem_ptr_q <= '0;
    end else begin
      pready_q <= PSEL_IN && !PENABLE_IN;
      if (PSEL_IN && !PENABLE_IN) begin
        prdata_q <= PWRITE_IN ? 32'h0000_0000 : rd_val;
        pslverr_q <= !rd_hit;
      end
      if (PSEL_IN && PENABLE_IN && pready_q && PWRITE_IN) begin
        if (PADDR_IN == qddr_pkg::REG_CFG_OFF) begin
          cfg_q <= PWDATA_IN[7:0];
        end else if (PADDR_IN == qddr_pkg::REG_PATTERN_OFF) begin
          pattern_q <= PWDATA_IN[7:0];
        end else if (PADDR_IN == qddr_pkg::REG_MEM_PTR_OFF) begin
          mem_ptr_q <= PWDATA_IN[MEM_AW-1:0];
        end else if (PADDR_IN == qddr_pkg::REG_MEM_DATA_OFF) begin
          mem_ptr_q <= mem_ptr_q + 1'b1;
        end
      end
    end
  end

  // Array has no reset; software loads it before reading
  always_ff @(posedge REF_CLK_IN) begin
    if (PSEL_IN && PENABLE_IN && pready_q && PWRITE_IN &&
        PADDR_IN == qddr_pkg::REG_MEM_DATA_OFF) begin
      mem[mem_ptr_q] <= PWDATA_IN[7:0];
    end
  end

  assign PREADY_OUT = pready_q;
  assign PRDATA_OUT = prdata_q;
  assign PSLVERR_OUT = pslverr_q;
  assign SIO_OUT = out_q;
  assign SIO_OE_OUT = oe_q;

  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (!RSTN_IN);

  quad_gate_a: assert property (
    state_q == qddr_pkg::ST_CMD && sck_rise && !cs_fall && cnt_q == 5'h01 &&
    !cfg_q[qddr_pkg::CFG_QUAD_BIT] |=> state_q == qddr_pkg::ST_SKIP)
    else $error("read accepted with quad disabled");
  addr_width_a: assert property (
    state_q == qddr_pkg::ST_CMD && sck_rise && cnt_q == 5'h01 &&
    cfg_q[qddr_pkg::CFG_QUAD_BIT] && op == qddr_pkg::OP_QDDR_READ_4B
    |=> state_q == qddr_pkg::ST_ADDR && cnt_q == qddr_pkg::ADDR_NIB_4B)
    else $error("4-byte opcode gave wrong address length");
  addr_shift_a: assert property (
    state_q == qddr_pkg::ST_ADDR && nib_take && !cs_high |=> addr_q[3:0] == $past(io))
    else $error("address nibble not captured");
  dummy_len_a: assert property (
    state_q == qddr_pkg::ST_MODE && sck_fall |=> state_q == qddr_pkg::ST_DUMMY &&
    cnt_q == {$past(lc), 1'b1})
    else $error("dummy count not from latency code");
  dummy_quiet_a: assert property (
    state_q == qddr_pkg::ST_DUMMY && sck_edge && cnt_q > qddr_pkg::PREAMBLE_TOP
    |=> oe_q == 4'h0)
    else $error("bus driven early in dummy cycles");
  cont_enter_a: assert property (
    state_q == qddr_pkg::ST_MODE && sck_fall ##1 cont_q ##[1:200] cs_fall
    |=> state_q == qddr_pkg::ST_ADDR)
    else $error("continuous frame did not start with address");
  cont_exit_a: assert property (
    rise[1] && cont_frame_q && state_q == qddr_pkg::ST_ADDR && rises_q <= qddr_pkg::CONT_EXIT_MAX
    |=> !cont_q)
    else $error("short frame kept continuous mode");
  addr_step_a: assert property (
    state_q == qddr_pkg::ST_DATA && sck_fall |=> addr_q == $past(addr_q) + 32'h1)
    else $error("read address did not step");
  data_nib_a: assert property (
    state_q == qddr_pkg::ST_DATA && sck_rise |=> SIO_OUT == $past(mem_rd[7:4]) &&
    SIO_OE_OUT == 4'hF)
    else $error("high nibble not driven on rising edge");
  preamble_a: assert property (
    state_q == qddr_pkg::ST_DUMMY && sck_edge && cfg_q[qddr_pkg::CFG_LEARN_BIT] &&
    cnt_q == qddr_pkg::PREAMBLE_TOP |=> SIO_OE_OUT == 4'hF &&
    SIO_OUT == {4{pattern_q[7]}})
    else $error("preamble first bit missing");

  cont_mode_c: cover property (state_q == qddr_pkg::ST_MODE && sck_fall ##1 cont_q);
  data_run_c: cover property (state_q == qddr_pkg::ST_DATA && sck_fall);
  preamble_c: cover property (oe_q == 4'hF && state_q == qddr_pkg::ST_DUMMY);
  cont_exit_c: cover property (cont_q ##1 !cont_q);
endmodule : qddr_read_top
`default_nettype wire

// file: tb/qddr_host_model.sv
// Host serial controller model that frames quad DDR reads
`timescale 1ns/1ns
`default_nettype none
module qddr_host_model (
  input wire logic clk_in,
  input wire logic [3:0] dev_sio_in,
  input wire logic [3:0] dev_oe_in,
  output logic sck_out,
  output logic cs_n_out,
  output logic [3:0] sio_out
);
  logic sck_q = 1'b0;
  logic cs_n_q = 1'b1;
  logic [3:0] io_q = 4'h0;
  logic [3:0] drv_q = 4'h0;
  logic float_q = 1'b0;
  logic [7:0] smp;
  logic [7:0] rx_q[$];
  // Released lines toggle so a stale value never passes for data
  always @(posedge clk_in) float_q <= ~float_q;
  assign sck_out = sck_q;
  assign cs_n_out = cs_n_q;
  assign sio_out = (dev_oe_in & dev_sio_in) | (~dev_oe_in & drv_q & io_q)
    | (~dev_oe_in & ~drv_q & {4{float_q}});
  // Four clocks per half period: 200 ns, far below the speed ceiling
  task automatic step(input logic lvl, input logic [3:0] d, input logic [3:0] drv);
    @(posedge clk_in);
    io_q <= d;
    drv_q <= drv;
    @(posedge clk_in);
    sck_q <= lvl;
    repeat (2) @(posedge clk_in);
    // One capture point, two clocks after the edge, serves preamble and data alike
    smp = {dev_oe_in, dev_sio_in};
  endtask : step
  task automatic select(input logic lvl);
    @(posedge clk_in);
    cs_n_q <= lvl;
    repeat (3) @(posedge clk_in);
  endtask : select
  task automatic frame(input logic cont, input logic [7:0] op, input int nib,
      input logic [31:0] addr, input logic [7:0] mode, input int dum, input int nbyte);
    rx_q.delete();
    select(1'b0);
    if (!cont) begin
      for (int i = 7; i >= 0; i--) begin
        step(1'b1, {3'b000, op[i]}, 4'h1);
        step(1'b0, {3'b000, op[i]}, 4'h1);
      end
    end
    for (int i = nib - 1; i >= 0; i--) step(i[0], addr[4*i+:4], 4'hF);
    step(1'b1, mode[7:4], 4'hF);
    step(1'b0, mode[3:0], 4'hF);
    // Released after the mode byte, so the preamble never meets contention
    for (int i = 0; i < 2 * (dum + nbyte) + 2; i++) begin
      step(~i[0], 4'h0, 4'h0);
      if (i > 0) rx_q.push_back(smp);
    end
    select(1'b1);
    repeat (4) @(posedge clk_in);
  endtask : frame
  task automatic stub(input int n);
    select(1'b0);
    repeat (n) begin
      step(1'b1, 4'h0, 4'hF);
      step(1'b0, 4'h0, 4'hF);
    end
    select(1'b1);
  endtask : stub
endmodule : qddr_host_model
`default_nettype wire

// file: tb/qddr_read_top_tb.sv
// Self-checking bench for the quad DDR read block
`timescale 1ns/1ns
`default_nettype none
module qddr_read_top_tb;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  wire logic sck;
  wire logic cs_n;
  wire logic [3:0] sio_in;
  wire logic [3:0] sio_out;
  wire logic [3:0] sio_oe;
  int num_errors = 0;
  int n_compared = 0;
  logic [31:0] rd;
  logic err;
  always #25 ref_clk = ~ref_clk;
  qddr_read_top #(.MEM_AW(8)) qddr_read_top_inst (.REF_CLK_IN(ref_clk), .RSTN_IN(rstn),
    .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr),
    .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
    .SCK_IN(sck), .CS_N_IN(cs_n), .SIO_IN(sio_in), .SIO_OUT(sio_out), .SIO_OE_OUT(sio_oe));
  qddr_host_model qddr_host_model_inst (.clk_in(ref_clk), .dev_sio_in(sio_out),
    .dev_oe_in(sio_oe), .sck_out(sck), .cs_n_out(cs_n), .sio_out(sio_in));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    // PREADY from the slave ends this wait, else the watchdog; the slave sets the pace
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge so a following setup never reassigns psel in the same step
    @(posedge ref_clk);
  endtask : apb
  // Array byte at address a holds a ^ 5A
  task automatic chk_data(input logic [7:0] start, input int dum, input int nb);
    logic [7:0] b;
    for (int k = 0; k < nb; k++) begin
      b = (start + k[7:0]) ^ 8'h5A;
      check("data high", qddr_host_model_inst.rx_q[2*dum+2*k], {4'hF, b[7:4]});
      check("data low", qddr_host_model_inst.rx_q[2*dum+2*k+1], {4'hF, b[3:0]});
    end
  endtask : chk_data
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict
  // Whole run is a few thousand clocks; this cuts a hang short
  initial begin
    repeat (40000) @(posedge ref_clk);
    num_errors++;
    give_verdict();
  end
  initial begin
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    apb(1'b0, qddr_pkg::REG_CFG_OFF, 32'h0);
    check("cfg reset", rd, {24'h0, qddr_pkg::CFG_RESET});
    apb(1'b0, qddr_pkg::REG_PATTERN_OFF, 32'h0);
    check("pattern reset", rd, {24'h0, qddr_pkg::PATTERN_RESET});
    apb(1'b0, 8'hFC, 32'h0);
    check("unmapped error", {31'h0, err}, 32'h1);
    for (int a = 0; a < 256; a++) begin
      apb(1'b1, qddr_pkg::REG_MEM_PTR_OFF, 32'(a));
      apb(1'b1, qddr_pkg::REG_MEM_DATA_OFF, 32'(a ^ 8'h5A));
    end
    $display("test registers done");
    apb(1'b1, qddr_pkg::REG_CFG_OFF, 32'h20);
    qddr_host_model_inst.frame(1'b0, qddr_pkg::OP_QDDR_READ, 6, 32'h10, 8'h00, 2, 1);
    check("quad off drive", {28'h0, qddr_host_model_inst.rx_q[4][7:4]}, 32'h0);
    apb(1'b1, qddr_pkg::REG_CFG_OFF, 32'h22);
    qddr_host_model_inst.frame(1'b0, qddr_pkg::OP_QDDR_READ, 6, 32'hFE, 8'hFF, 2, 4);
    chk_data(8'hFE, 2, 4);
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, qddr_pkg::REG_CFG_OFF, k ? 32'h23 : 32'h22);
      qddr_host_model_inst.frame(1'b0, k ? qddr_pkg::OP_QDDR_READ : qddr_pkg::OP_QDDR_READ_4B,
        8, 32'h1234_5640 + 32'(k), 8'h00, 2, 2);
      chk_data(8'h40 + 8'(k), 2, 2);
    end
    $display("test plain reads done");
    apb(1'b1, qddr_pkg::REG_CFG_OFF, 32'h56);
    apb(1'b1, qddr_pkg::REG_PATTERN_OFF, 32'hC3);
    qddr_host_model_inst.frame(1'b0, qddr_pkg::OP_QDDR_READ, 6, 32'h80, 8'h5A, 5, 2);
    check("no early preamble", {28'h0, qddr_host_model_inst.rx_q[1][7:4]}, 32'h0);
    for (int b = 0; b < 8; b++) begin
      check("preamble", qddr_host_model_inst.rx_q[2+b],
        ((8'hC3 & (8'h80 >> b)) != 8'h00) ? 32'h0000_00FF : 32'h0000_00F0);
    end
    chk_data(8'h80, 5, 2);
    apb(1'b0, qddr_pkg::REG_STATUS_OFF, 32'h0);
    check("continuous on", {31'h0, rd[7]}, 32'h1);
    qddr_host_model_inst.frame(1'b1, 8'h00, 6, 32'h33, 8'h00, 5, 1);
    chk_data(8'h33, 5, 1);
    qddr_host_model_inst.frame(1'b0, qddr_pkg::OP_QDDR_READ, 6, 32'hC0, 8'hA5, 5, 1);
    chk_data(8'hC0, 5, 1);
    // Two clocks leave the short frame still inside its address phase
    qddr_host_model_inst.stub(2);
    apb(1'b0, qddr_pkg::REG_STATUS_OFF, 32'h0);
    check("continuous off", {31'h0, rd[7]}, 32'h0);
    $display("test continuous mode done");
    give_verdict();
  end
endmodule : qddr_read_top_tb
`default_nettype wire
